// >>> bus_glue_pkg.sv
/*
 * Constants shared by the card and NAND pin glue.
 * Assumes a 32-bit internal transfer address and active-low strobes.
 */
package bus_glue_pkg;
    // ------------------------------------------------------------
    // Region decode
    // ------------------------------------------------------------
    localparam int          REGION_MSB       = 31;
    localparam int          REGION_LSB       = 28;
    localparam logic [3:0]  REGION_THREE     = 4'h4;
    localparam logic [3:0]  REGION_FOUR      = 4'h5;
    // ------------------------------------------------------------
    // Address bit roles
    // ------------------------------------------------------------
    localparam int          IO_MODE_BIT      = 23;
    localparam int          ATTR_SEL_BIT     = 22;
    localparam int          NAND_ALE_BIT     = 22;
    localparam int          NAND_CLE_BIT     = 21;
    localparam int          DIR_PIN_BIT      = 25;
    // ------------------------------------------------------------
    // Reset values (strobes idle high) and 16-bit width code
    // ------------------------------------------------------------
    localparam logic        STROBE_IDLE      = 1'b1;
    localparam logic        WIDTH_16_BIT     = 1'b1;
endpackage

// >>> pin_sync.sv
/*
 * Two-flop synchroniser for one level.
 * Assumes the level comes from outside the ref_clk domain.
 */
`timescale 1ns/1ps
module pin_sync (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_b,
    // Level in and out
    input  wire logic async_in,
    output logic      sync_out
);
    logic stage_one;

    // Only the second flop reads the first
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            stage_one <= 1'b1;
            sync_out  <= 1'b1;
        end else begin
            stage_one <= async_in;
            sync_out  <= stage_one;
        end
    end
endmodule

// >>> card_and_nand_bus_glue.sv
/*
 * Pin glue between the static memory controller and the card slot
 * and NAND pins. Assumes controller outputs are on ref_clk, active low.
 */
`timescale 1ns/1ps
module card_and_nand_bus_glue (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    // Assignment bits and region width
    input  wire logic        card_logic_assign,
    input  wire logic        nand_logic_assign,
    input  wire logic        bus_width_field,
    // Static controller side
    input  wire logic [31:0] xfer_addr,
    input  wire logic        xfer_write,
    input  wire logic        xfer_half,
    input  wire logic        region_three_select_in,
    input  wire logic        region_four_select_in,
    input  wire logic        region_five_select_in,
    input  wire logic        region_six_select_in,
    input  wire logic        smc_read_b,
    input  wire logic        smc_write_b,
    input  wire logic        byte1_write_strobe_in,
    input  wire logic        byte3_write_strobe_in,
    input  wire logic        burst_addr_advance_in,
    // Pins from outside
    input  wire logic        ready_pad_in,
    // Dedicated card pins
    output logic             region_four_pin,
    output logic             region_five_pin,
    output logic             region_six_pin,
    // Shared strobe pins
    output logic             read_pin,
    output logic             write_pin,
    output logic             byte1_pin,
    output logic             byte3_pin,
    output logic             addr_hi_pin,
    output logic             attr_select_pin,
    // NAND pins and the burst ready return
    output logic             ready_pad_out,
    output logic             ready_pad_oe,
    output logic             advance_pin,
    output logic             nand_ale,
    output logic             nand_cle,
    output logic             burst_ready_in
);
    // ------------------------------------------------------------
    // Region decode
    // ------------------------------------------------------------
    logic [3:0] region;
    logic       card_access;
    logic       nand_access;
    logic       io_mode;
    logic       lower_b;
    logic       upper_b;
    logic       odd_low;
    logic       card_read_b;
    logic       card_write_b;
    logic       card_ior_b;
    logic       card_iow_b;
    logic       nand_read_b;
    logic       nand_write_b;
    logic       ready_sync;

    assign region = xfer_addr[bus_glue_pkg::REGION_MSB:
                              bus_glue_pkg::REGION_LSB];
    assign card_access = card_logic_assign
                       && (region == bus_glue_pkg::REGION_FOUR);
    assign nand_access = nand_logic_assign
                       && (region == bus_glue_pkg::REGION_THREE)
                       && !region_three_select_in;
    assign io_mode = xfer_addr[bus_glue_pkg::IO_MODE_BIT];

    // ------------------------------------------------------------
    // Byte enables
    // ------------------------------------------------------------
    // odd low-lane byte only at 8-bit width
    assign odd_low = (bus_width_field != bus_glue_pkg::WIDTH_16_BIT)
                   && xfer_addr[0];
    // lane selection; enables gated by region-four select
    assign lower_b = region_four_select_in
                   | (xfer_addr[0] & !odd_low & !xfer_half);
    assign upper_b = region_four_select_in
                   | odd_low
                   | (!xfer_addr[0] & !xfer_half);

    // ------------------------------------------------------------
    // Strobe steering
    // ------------------------------------------------------------
    // I/O mode uses I/O strobes, memory strobes held idle
    assign card_read_b  = io_mode ? bus_glue_pkg::STROBE_IDLE : smc_read_b;
    assign card_write_b = io_mode ? bus_glue_pkg::STROBE_IDLE : smc_write_b;
    assign card_ior_b   = io_mode ? smc_read_b : bus_glue_pkg::STROBE_IDLE;
    assign card_iow_b   = io_mode ? smc_write_b : bus_glue_pkg::STROBE_IDLE;
    // NAND strobes only inside region three
    assign nand_read_b  = nand_access ? smc_read_b
                                      : bus_glue_pkg::STROBE_IDLE;
    assign nand_write_b = nand_access ? smc_write_b
                                      : bus_glue_pkg::STROBE_IDLE;

    // Ready pad is an outside level, so synchronise it first
    pin_sync ready_sync_u (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .async_in (ready_pad_in),
        .sync_out (ready_sync)
    );

    // ------------------------------------------------------------
    // Registered pins
    // ------------------------------------------------------------
    // Every pin is registered: all inputs but the ready pad take one cycle to a pin (ready pad takes three),
    // so relative timing between select and enables is kept.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            region_four_pin <= bus_glue_pkg::STROBE_IDLE;
            region_five_pin <= bus_glue_pkg::STROBE_IDLE;
            region_six_pin  <= bus_glue_pkg::STROBE_IDLE;
            read_pin        <= bus_glue_pkg::STROBE_IDLE;
            write_pin       <= bus_glue_pkg::STROBE_IDLE;
            byte1_pin       <= bus_glue_pkg::STROBE_IDLE;
            byte3_pin       <= bus_glue_pkg::STROBE_IDLE;
            addr_hi_pin     <= 1'b0;
            attr_select_pin <= 1'b0;
            ready_pad_out   <= bus_glue_pkg::STROBE_IDLE;
            ready_pad_oe    <= 1'b0;
            advance_pin     <= bus_glue_pkg::STROBE_IDLE;
            nand_ale        <= 1'b0;
            nand_cle        <= 1'b0;
            burst_ready_in  <= 1'b1;
        end else begin
            // dedicated pins; buffer select is region-four select
            region_four_pin <= region_four_select_in;
            region_five_pin <= card_logic_assign ? lower_b
                                                 : region_five_select_in;
            region_six_pin  <= card_logic_assign ? upper_b
                                                 : region_six_select_in;
            read_pin  <= card_access ? card_read_b  : smc_read_b;
            write_pin <= card_access ? card_write_b : smc_write_b;
            byte1_pin <= card_access ? card_ior_b   : byte1_write_strobe_in;
            byte3_pin <= card_access ? card_iow_b   : byte3_write_strobe_in;
            // direction from the write flag for card accesses, else A25, stable over transfer
            addr_hi_pin <= card_access ? !xfer_write
                                       : xfer_addr[bus_glue_pkg::DIR_PIN_BIT];
            attr_select_pin <= xfer_addr[bus_glue_pkg::ATTR_SEL_BIT];
            // assign bit picks pin function and pad direction
            ready_pad_oe  <= nand_logic_assign;
            ready_pad_out <= nand_read_b;
            advance_pin   <= nand_logic_assign ? nand_write_b
                                               : burst_addr_advance_in;
            burst_ready_in <= nand_logic_assign ? 1'b1 : ready_sync;
            // latch enables from A22 and A21
            nand_ale <= xfer_addr[bus_glue_pkg::NAND_ALE_BIT];
            nand_cle <= xfer_addr[bus_glue_pkg::NAND_CLE_BIT];
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence card_cycle_s;
        card_access && !smc_read_b;
    endsequence

    buffer_select_a: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        1'b1 |=> region_four_pin == $past(region_four_select_in))
        else $error("buffer select differs from region-four select");

    enables_idle_a: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        card_logic_assign && region_four_select_in |=>
        region_five_pin && region_six_pin)
        else $error("card byte enable active outside select");

    odd_byte_a: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        card_logic_assign && !region_four_select_in && xfer_addr[0]
        && !xfer_half && !bus_width_field |=>
        !region_five_pin && region_six_pin)
        else $error("odd low byte wrongly enabled");

    half_word_a: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        card_logic_assign && !region_four_select_in && xfer_half |=>
        !region_five_pin && !region_six_pin)
        else $error("half-word enables wrong");

    io_mode_a: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        card_cycle_s and io_mode |=> !byte1_pin && read_pin)
        else $error("I/O read not routed");

    mem_mode_a: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        card_cycle_s and !io_mode |=> !read_pin && byte1_pin)
        else $error("memory read not routed");

    nand_leave_a: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        !nand_access |=> ready_pad_out && (!nand_logic_assign
                                           || $past(nand_logic_assign)
                                              == 1'b0 || advance_pin))
        else $error("NAND strobe active outside region three");

    pad_dir_a: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        1'b1 |=> ready_pad_oe == $past(nand_logic_assign))
        else $error("ready pad direction wrong");

    latch_a: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        1'b1 |=>
        nand_ale == $past(xfer_addr[bus_glue_pkg::NAND_ALE_BIT])
        && nand_cle == $past(xfer_addr[bus_glue_pkg::NAND_CLE_BIT]))
        else $error("NAND latch enables wrong");
endmodule

// >>> card_slot_model.sv
/*
 * Far-side model: burst ready source sharing the ready pad.
 * Assumes the glue drives the pad only while its enable is high.
 */
`timescale 1ns/1ps
module card_slot_model (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_b,
    // Shared ready pad
    input  wire logic ready_pad_out,
    input  wire logic ready_pad_oe,
    output logic      pad_wire
);
    // ------------------------------------------------------------
    // Burst ready source
    // ------------------------------------------------------------
    logic [2:0] tick;
    logic       ready_level;

    // Slow toggle, so the synchroniser sees settled levels
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tick        <= 3'h0;
            ready_level <= 1'b1;
        end else begin
            tick <= tick + 3'h1;
            if (tick == 3'h7) begin
                ready_level <= ~ready_level;
            end
        end
    end

    // pad direction
    // The glue wins while it drives; otherwise the ready source
    assign pad_wire = ready_pad_oe ? ready_pad_out : ready_level;
endmodule

// >>> card_and_nand_bus_glue_tb.sv
/*
 * Self-checking bench for the card and NAND pin glue.
 * Assumes every output but burst ready settles one ref_clk cycle after its inputs.
 */
`timescale 1ns/1ps
module card_and_nand_bus_glue_tb;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        ref_clk, rst_b, card_on, nand_on, width16, half, wr;
    logic        s3, s4, s5, s6, rd_b, wr_b, b1_in, b3_in, adv_in, pad;
    logic [31:0] a;
    logic        p4, p5, p6, prd, pwr, pb1, pb3, pahi, pattr, rpo, roe;
    logic        padv, ale, cle, bri, armed;
    logic [13:0] got, ev;
    logic [15:0] lf;
    logic [3:0]  hist;
    logic [1:0]  nh;
    int          error_cnt, check_count;
    logic [31:0] ca [10] = '{32'h5080_0000, 32'h5080_0001, 32'h5000_0001,
        32'h5040_0000, 32'h5000_0002, 32'h4020_0000, 32'h4040_0000,
        32'h1000_0000, 32'h5080_0000, 32'h0000_0000};
    logic [7:0]  cc [10] = '{8'ha4, 8'h8c, 8'ha4, 8'hbc, 8'h84, 8'h6c,
        8'h64, 8'h66, 8'h24, 8'h00};

    assign got = {p4, p5, p6, prd, pwr, pb1, pb3, pahi, pattr, rpo, roe,
                  padv, ale, cle};

    card_and_nand_bus_glue DUT (.ref_clk(ref_clk), .rst_b(rst_b),
        .card_logic_assign(card_on), .nand_logic_assign(nand_on),
        .bus_width_field(width16), .xfer_addr(a), .xfer_write(wr),
        .xfer_half(half), .region_three_select_in(s3),
        .region_four_select_in(s4), .region_five_select_in(s5),
        .region_six_select_in(s6), .smc_read_b(rd_b), .smc_write_b(wr_b),
        .byte1_write_strobe_in(b1_in), .byte3_write_strobe_in(b3_in),
        .burst_addr_advance_in(adv_in), .ready_pad_in(pad),
        .region_four_pin(p4), .region_five_pin(p5), .region_six_pin(p6),
        .read_pin(prd), .write_pin(pwr), .byte1_pin(pb1), .byte3_pin(pb3),
        .addr_hi_pin(pahi), .attr_select_pin(pattr), .ready_pad_out(rpo),
        .ready_pad_oe(roe), .advance_pin(padv), .nand_ale(ale),
        .nand_cle(cle), .burst_ready_in(bri));

    card_slot_model partner (.ref_clk(ref_clk), .rst_b(rst_b),
        .ready_pad_out(rpo), .ready_pad_oe(roe), .pad_wire(pad));

    // Clock at 125 MHz
    always #4 ref_clk = ~ref_clk;

    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    // Expected pin image for the inputs now applied
    function automatic logic [13:0] exp_vec();
        logic card, io, flash, lo, up;
        card  = card_on && a[31:28] == bus_glue_pkg::REGION_FOUR;
        flash = nand_on && a[31:28] == bus_glue_pkg::REGION_THREE && !s3;
        io   = a[23];
        lo   = s4 | ~(half | ~a[0] | ~width16);
        up   = s4 | ~(half | (a[0] & width16));
        return {s4, card_on ? lo : s5, card_on ? up : s6,
                card ? io | rd_b : rd_b, card ? io | wr_b : wr_b,
                card ? ~io | rd_b : b1_in, card ? ~io | wr_b : b3_in,
                card ? ~wr : a[25], a[22], flash ? rd_b : 1'b1, nand_on,
                nand_on ? (flash ? wr_b : 1'b1) : adv_in, a[22], a[21]};
    endfunction

    task automatic bad(input string m);
        error_cnt++;
        $display("[FAIL] t=%0t %s got=%h exp=%h", $time, m, got, ev);
    endtask

    // Check the last cycle, then apply one access
    task automatic cyc(input logic [31:0] ad, input logic [7:0] c);
        @(posedge ref_clk);
        #1;
        hist = {hist[2:0], pad};
        nh   = {nh[0], nand_on};
        if (armed) begin
            check_count++;
            if (got !== ev) bad("pin map");
            check_count++;
            if (nh == 2'b11 && bri !== 1'b1) bad("ready held");
            if (nh == 2'b00 && (hist == 4'h0 || hist == 4'hf) &&
                bri !== hist[0]) bad("ready pass");
        end
        {card_on, nand_on, width16, half, wr} = c[7:3];
        a    = ad;
        rd_b = ~(c[2] & ~wr);
        wr_b = ~(c[2] & wr);
        s3   = ~(c[2] & a[31:28] == bus_glue_pkg::REGION_THREE | c[1]);
        s4   = ~(c[2] & a[31:28] == bus_glue_pkg::REGION_FOUR);
        s5   = ~(c[2] & a[31:28] == 4'h6);
        s6   = ~(c[2] & a[31:28] == 4'h7);
        lf   = lfsr(lf);
        {b1_in, b3_in, adv_in} = lf[2:0];
        ev    = exp_vec();
        armed = 1'b1;
    endtask

    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Watchdog sized well beyond the expected run
    initial begin
        #(8 * 6000);
        error_cnt++;
        complete_run();
    end

    initial begin
        logic [15:0] hi;
        logic [31:0] ad;
        logic [7:0]  c;
        {ref_clk, rst_b, armed, a, lf, hist, nh} = '0;
        {card_on, nand_on, width16, half, wr} = '0;
        {s3, s4, s5, s6, rd_b, wr_b, b1_in, b3_in, adv_in} = '1;
        lf = 16'h0012;
        repeat (16) @(posedge ref_clk);
        check_count++;
        if (got !== 14'h3f94 || bri !== 1'b1) bad("reset");
        #1 rst_b = 1'b1;
        // Hand-picked lanes, modes, NAND latches and a stray select
        for (int i = 0; i < 10; i++) cyc(ca[i], cc[i]);
        $display("corner test done");
        // widths, regions and chip enable kept legal
        for (int i = 0; i < 2000; i++) begin
            lf = lfsr(lf);
            hi = lf;
            lf = lfsr(lf);
            ad = {hi, lf};
            ad[31:28] = ad[29] ? {3'h2, ad[28]} : {1'b0, ad[28], 2'h2};
            if (i[6] && ad[31:28] == 4'h6) ad[31:28] = 4'h0;
            // Half-word forces 16-bit width so lanes stay legal
            c = {i[6], i[7], lf[7] | lf[6], lf[6:4], 2'b00};
            cyc(ad, c);
        end
        cyc(32'h0, 8'h00);
        $display("random test done");
        complete_run();
    end
endmodule
